/* File: rtl/dsn_pkg.sv */
// package: serial number register map, field layout and constants
//
// Contract
// - fifty-six bit serial number spread over consecutive read-only registers.
// - characters are six bits: 0-9 then A-Z, codes above Z never produced.
// - word 0x05: second char lsb at 7, third char 6:1, fourth char msb at 0.
// - word 0x06: fourth char low five bits at 7:3, decimal msbs at 2:0.
// - decimal field is one seven-bit binary value 0-127; its low bits sit at 0x07 7:4.
// - wafer is five bits 1-31; upper four at 0x07 3:0, lsb at 0x08 bit 7.
// - word 0x08 bits 6:0 return x die coordinate bits 8:2.
// - y coordinate upper bits at 0x09 7:1, three lowest at 0x0A 7:5.
// - word 0x09 bit 0 returns the serial number parity bit.
// - word 0x0A bits 3:0 return the four-bit crc, treated as opaque.
// - every serial word is read-only and reads zero after reset.
// - preceding word 0x04 bits 4:0 hold the second char upper five bits.
package dsn_pkg;
  // ==========================================================
  // bus and storage
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int REG_W = 8;
  localparam int IMG_W = 56;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;
  localparam int STORE_DEPTH = 7;
  localparam int STORE_AW = 3;
  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_WORD0 = 6'h04;
  localparam logic [IDX_W-1:0] IDX_WORD1 = 6'h05;
  localparam logic [IDX_W-1:0] IDX_WORD2 = 6'h06;
  localparam logic [IDX_W-1:0] IDX_WORD3 = 6'h07;
  localparam logic [IDX_W-1:0] IDX_WORD4 = 6'h08;
  localparam logic [IDX_W-1:0] IDX_WORD5 = 6'h09;
  localparam logic [IDX_W-1:0] IDX_WORD6 = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h20;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h21;
  localparam logic [REG_W-1:0] WORD_RESET = 8'h00;
  localparam logic [REG_W-1:0] WORD_FULL = 8'hFF;
  localparam logic [REG_W-1:0] WORD6_MASK = 8'hEF;
  // ==========================================================
  // field layout inside the packed image, word 0x04 in the top byte
  localparam int CHAR_W = 6;
  localparam int CHAR_NUM = 3;
  localparam logic [CHAR_W-1:0] CHAR_MAX = 6'h23;
  localparam int CHAR_LSB [CHAR_NUM] = '{47, 41, 35};
  localparam int FAB_LSB = 53;
  localparam int FAB_W = 3;
  localparam int DEC_LSB = 28;
  localparam int DEC_W = 7;
  localparam int WAFER_LSB = 23;
  localparam int WAFER_W = 5;
  localparam int XHI_LSB = 16;
  localparam int YHI_LSB = 9;
  localparam int COORD_HI_W = 7;
  localparam int PARITY_POS = 8;
  localparam int YLO_LSB = 5;
  localparam int YLO_W = 3;
  localparam int CRC_LSB = 0;
  localparam int CRC_W = 4;
  // ==========================================================
  // own status and control bits
  localparam int ST_LOADED_BIT = 0;
  localparam int ST_CHARS_BIT = 1;
  localparam int ST_WAFER_BIT = 2;
  localparam int CTRL_MASK_BIT = 0;
endpackage

/* File: rtl/dsn_byte_store.sv */
// small byte memory holding the serial image, registered read port
`timescale 1ns/1ps
module dsn_byte_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 7,
  parameter int AW = 3
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  // read port
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array; the owner gates reads until a load completes
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // dsn_byte_store

/* File: rtl/dsn_field_check.sv */
// plausibility check of character and wafer fields of a serial image
`timescale 1ns/1ps
module dsn_field_check
  import dsn_pkg::*;
(
  // image under test
  input wire logic [IMG_W-1:0] image,
  // verdicts
  output logic charsOk,
  output logic waferOk
);
  logic [CHAR_NUM-1:0] charOk;

  genvar gi;
  generate
    for (gi = 0; gi < CHAR_NUM; gi++) begin : g_char
      assign charOk[gi] = image[CHAR_LSB[gi] +: CHAR_W] <= CHAR_MAX;
    end
  endgenerate

  assign charsOk = &charOk;
  // wafer zero is never issued, so a zero field marks a bad image
  assign waferOk = |image[WAFER_LSB +: WAFER_W];
endmodule // dsn_field_check

/* File: rtl/dsn_serial_regs.sv */
// serial number register bank with apb slave and image loader
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module dsn_serial_regs
  import dsn_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W/8-1:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // factory image load
  input wire logic fuseLoad,
  input wire logic [IMG_W-1:0] fuseImage
);
  // ==========================================================
  // state
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_FETCH, ST_RESP, ST_LOAD} dsn_state_e;

  typedef struct packed {
    dsn_state_e state;
    logic [DATA_W-1:0] prdata;
    logic slverr;
    logic [IMG_W-1:0] loadImg;
    logic loadPend;
    logic [STORE_AW-1:0] loadIdx;
    logic loaded;
    logic charsOk;
    logic waferOk;
    logic maskInvalid;
  } dsn_regs_s;

  dsn_regs_s regs_reg;
  dsn_regs_s regs_next;

  logic [IDX_W-1:0] rdIdx;
  logic [REG_W-1:0] memData;
  logic [STORE_AW-1:0] memRdAddr;
  logic memWe;
  logic chkChars;
  logic chkWafer;
  logic isSerial;
  logic serveOk;
  logic setupCyc;
  logic accessCyc;

  // ==========================================================
  // address decode
  assign rdIdx = paddr[ADDR_W-1:IDX_LSB];
  assign isSerial = (rdIdx >= IDX_WORD0) && (rdIdx <= IDX_WORD6);
  assign memRdAddr = STORE_AW'(rdIdx - IDX_WORD0);
  assign setupCyc = psel && !penable;
  assign accessCyc = psel && penable;
  // a bad image can be hidden by software instead of exposing junk
  assign serveOk = regs_reg.loaded && !(regs_reg.maskInvalid && !(regs_reg.charsOk && regs_reg.waferOk));
  assign memWe = (regs_reg.state == ST_LOAD);

  // ==========================================================
  // submodules
  dsn_byte_store #(
    .WIDTH(REG_W),
    .DEPTH(STORE_DEPTH),
    .AW(STORE_AW)
  ) u_store (
    .clk(clk),
    .wrEn(memWe),
    .wrAddr(regs_reg.loadIdx),
    .wrData(regs_reg.loadImg[IMG_W-1 -: REG_W]),
    .rdAddr(memRdAddr),
    .rdData(memData)
  );

  dsn_field_check u_check (
    .image(fuseImage),
    .charsOk(chkChars),
    .waferOk(chkWafer)
  );

  // ==========================================================
  // next state
  always_comb begin
    regs_next = regs_reg;
    // a new image is held pending; one arriving mid-load is dropped
    if (fuseLoad && regs_reg.state != ST_LOAD) begin
      regs_next.loadImg = fuseImage;
      regs_next.loadPend = 1'b1;
      regs_next.charsOk = chkChars;
      regs_next.waferOk = chkWafer;
    end
    case (regs_reg.state)
      ST_IDLE: begin
        if (regs_reg.loadPend) begin
          regs_next.state = ST_LOAD;
          regs_next.loadIdx = '0;
          regs_next.loadPend = 1'b0;
          regs_next.loaded = 1'b0;
        end else if (setupCyc) begin
          regs_next.state = ST_FETCH;
        end else if (accessCyc) begin
          regs_next.state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        regs_next.state = ST_FETCH;
      end
      ST_FETCH: begin
        regs_next.state = ST_RESP;
        regs_next.slverr = 1'b0;
        regs_next.prdata = '0;
        if (paddr[IDX_LSB-1:0] != '0) begin
          regs_next.slverr = 1'b1;
        end else if (isSerial) begin
          // serial words are read-only: writes fall through untouched
          if (!pwrite && serveOk) begin
            regs_next.prdata[REG_W-1:0] = memData & ((rdIdx == IDX_WORD6) ? WORD6_MASK : WORD_FULL);
          end
        end else if (rdIdx == IDX_STATUS) begin
          regs_next.prdata[ST_LOADED_BIT] = regs_reg.loaded;
          regs_next.prdata[ST_CHARS_BIT] = regs_reg.charsOk;
          regs_next.prdata[ST_WAFER_BIT] = regs_reg.waferOk;
        end else if (rdIdx == IDX_CTRL) begin
          regs_next.prdata[CTRL_MASK_BIT] = regs_reg.maskInvalid;
        end else begin
          regs_next.slverr = 1'b1;
        end
      end
      ST_RESP: begin
        if (accessCyc && pwrite && !regs_reg.slverr && rdIdx == IDX_CTRL && pstrb[0]) begin
          regs_next.maskInvalid = pwdata[CTRL_MASK_BIT];
        end
        regs_next.state = ST_IDLE;
      end
      ST_LOAD: begin
        // one byte per cycle, top byte first, word 0x04 upward
        regs_next.loadImg = {regs_reg.loadImg[IMG_W-REG_W-1:0], WORD_RESET};
        regs_next.loadIdx = regs_reg.loadIdx + 1'b1;
        if (regs_reg.loadIdx == STORE_AW'(STORE_DEPTH - 1)) begin
          regs_next.loaded = 1'b1;
          regs_next.loadIdx = '0;
          regs_next.state = psel ? ST_ADDR : ST_IDLE;
        end
      end
      default: begin
        regs_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regs_reg <= '0;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = regs_reg.prdata;
  assign pready = (regs_reg.state == ST_RESP);
  assign pslverr = (regs_reg.state == ST_RESP) && regs_reg.slverr;

  // ==========================================================
  // checking helpers: image as it stands in the store
  logic [IMG_W-1:0] shadowImg;
  logic [CHAR_W-1:0] secondC;
  logic [CHAR_W-1:0] thirdC;
  logic [CHAR_W-1:0] fourthC;
  logic readHit;
  logic servedRead;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadowImg <= '0;
    end else if (regs_reg.state == ST_IDLE && regs_reg.loadPend) begin
      shadowImg <= regs_reg.loadImg;
    end
  end

  assign secondC = shadowImg[CHAR_LSB[0] +: CHAR_W];
  assign thirdC = shadowImg[CHAR_LSB[1] +: CHAR_W];
  assign fourthC = shadowImg[CHAR_LSB[2] +: CHAR_W];
  assign readHit = pready && !pwrite && !pslverr;
  assign servedRead = readHit && serveOk;

  // ==========================================================
  // byte of the shadow image picked by the current index
  logic [REG_W-1:0] shadowByte;
  logic [STORE_AW-1:0] shadowSel;

  // loop instead of a wide shift keeps the slice widths obvious
  always_comb begin
    shadowSel = memRdAddr;
    shadowByte = WORD_RESET;
    for (int i = 0; i < STORE_DEPTH; i++) begin
      if (shadowSel == STORE_AW'(i)) begin
        shadowByte = shadowImg[IMG_W-1-REG_W*i -: REG_W];
      end
    end
  end

  sequence setupSeq;
    regs_reg.state == ST_IDLE && !regs_reg.loadPend && setupCyc;
  endsequence

  sequence answerSeq;
    !pready ##1 pready;
  endsequence

  // ==========================================================
  // assertions
  word0_layout_a: assert property (@(posedge clk) disable iff (sys_rst)
    servedRead && rdIdx == IDX_WORD0 |->
      prdata[REG_W-1:0] == {shadowImg[FAB_LSB +: FAB_W], secondC[CHAR_W-1:1]})
    else $error("word 0x04 layout wrong");

  word1_layout_a: assert property (@(posedge clk) disable iff (sys_rst)
    servedRead && rdIdx == IDX_WORD1 |->
      prdata[REG_W-1:0] == {secondC[0], thirdC, fourthC[CHAR_W-1]})
    else $error("word 0x05 layout wrong");

  word2_layout_a: assert property (@(posedge clk) disable iff (sys_rst)
    servedRead && rdIdx == IDX_WORD2 |->
      prdata[REG_W-1:0] == {fourthC[CHAR_W-2:0], shadowImg[DEC_LSB+4 +: 3]})
    else $error("word 0x06 layout wrong");

  word3_layout_a: assert property (@(posedge clk) disable iff (sys_rst)
    servedRead && rdIdx == IDX_WORD3 |->
      prdata[REG_W-1:0] == {shadowImg[DEC_LSB +: 4], shadowImg[WAFER_LSB+1 +: 4]})
    else $error("word 0x07 layout wrong");

  word4_layout_a: assert property (@(posedge clk) disable iff (sys_rst)
    servedRead && rdIdx == IDX_WORD4 |->
      prdata[REG_W-1:0] == {shadowImg[WAFER_LSB], shadowImg[XHI_LSB +: COORD_HI_W]})
    else $error("word 0x08 layout wrong");

  word5_layout_a: assert property (@(posedge clk) disable iff (sys_rst)
    servedRead && rdIdx == IDX_WORD5 |->
      prdata[REG_W-1:0] == {shadowImg[YHI_LSB +: COORD_HI_W], shadowImg[PARITY_POS]})
    else $error("word 0x09 layout wrong");

  word6_layout_a: assert property (@(posedge clk) disable iff (sys_rst)
    servedRead && rdIdx == IDX_WORD6 |->
      prdata[REG_W-1:0] == {shadowImg[YLO_LSB +: YLO_W], 1'b0, shadowImg[CRC_LSB +: CRC_W]})
    else $error("word 0x0A layout wrong");

  serial_width_a: assert property (@(posedge clk) disable iff (sys_rst)
    readHit && isSerial |-> prdata[DATA_W-1:REG_W] == '0)
    else $error("serial word upper bits not zero");

  unloaded_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    readHit && isSerial && !regs_reg.loaded |-> prdata == '0)
    else $error("serial word nonzero before load");

  char_verdict_a: assert property (@(posedge clk) disable iff (sys_rst)
    regs_reg.loaded && regs_reg.state == ST_IDLE && !regs_reg.loadPend |->
      regs_reg.charsOk == (secondC <= CHAR_MAX && thirdC <= CHAR_MAX && fourthC <= CHAR_MAX))
    else $error("character verdict does not match image");

  ro_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    pready && pwrite && isSerial |=> $stable(shadowImg) && !memWe && $stable(regs_reg.maskInvalid))
    else $error("write to serial word changed state");

  read_latency_a: assert property (@(posedge clk) disable iff (sys_rst)
    setupSeq |=> answerSeq)
    else $error("read answer not on second access cycle");

  load_length_a: assert property (@(posedge clk) disable iff (sys_rst)
    regs_reg.state == ST_IDLE && regs_reg.loadPend |=> memWe [*7] ##1 regs_reg.loaded && !memWe)
    else $error("image load not seven bytes long");

  // ==========================================================
  // bus response checks
  serial_byte_a: assert property (@(posedge clk) disable iff (sys_rst)
    servedRead && isSerial && rdIdx != IDX_WORD6 |-> prdata[REG_W-1:0] == shadowByte)
    else $error("serial word differs from stored image");

  reset_quiet_a: assert property (@(posedge clk)
    $past(sys_rst) |-> !pready && !pslverr && prdata == '0)
    else $error("outputs not quiet after reset");

  ready_single_a: assert property (@(posedge clk) disable iff (sys_rst)
    pready |=> !pready)
    else $error("ready high for more than one cycle");

  err_with_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
    pslverr |-> pready && prdata == '0)
    else $error("error without ready or with data");

  misaligned_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    pready && paddr[IDX_LSB-1:0] != '0 |-> pslverr)
    else $error("misaligned access not refused");

  serial_no_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    pready && isSerial && paddr[IDX_LSB-1:0] == '0 |-> !pslverr)
    else $error("serial word access refused");

  prdata_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !pready |-> $stable(prdata))
    else $error("read data changed between answers");

  status_layout_a: assert property (@(posedge clk) disable iff (sys_rst)
    readHit && rdIdx == IDX_STATUS |->
      prdata == DATA_W'({regs_reg.waferOk, regs_reg.charsOk, regs_reg.loaded}))
    else $error("status word layout wrong");

  ctrl_readback_a: assert property (@(posedge clk) disable iff (sys_rst)
    readHit && rdIdx == IDX_CTRL |-> prdata == DATA_W'(regs_reg.maskInvalid))
    else $error("control word readback wrong");

  masked_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    readHit && isSerial && regs_reg.maskInvalid && !(regs_reg.charsOk && regs_reg.waferOk) |->
      prdata == '0)
    else $error("masked image still visible");

  // ==========================================================
  // loader checks
  wafer_verdict_a: assert property (@(posedge clk) disable iff (sys_rst)
    regs_reg.loaded && regs_reg.state == ST_IDLE && !regs_reg.loadPend |->
      regs_reg.waferOk == (shadowImg[WAFER_LSB +: WAFER_W] != '0))
    else $error("wafer verdict does not match image");

  load_no_pend_a: assert property (@(posedge clk) disable iff (sys_rst)
    memWe |-> !regs_reg.loadPend)
    else $error("load accepted while loading");

  load_unloaded_a: assert property (@(posedge clk) disable iff (sys_rst)
    memWe |-> !regs_reg.loaded)
    else $error("loaded flag high during load");

  status_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
    pready && pwrite && rdIdx == IDX_STATUS |=> $stable(regs_reg.maskInvalid) && !memWe)
    else $error("write to status changed state");
endmodule // dsn_serial_regs

/* File: verif/dsn_serial_regs_tb.sv */
// self-checking bench for the serial number register bank
`timescale 1ns/1ps
module dsn_serial_regs_tb;
  import dsn_pkg::*;
  // ==========================================================
  // design ports
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic err;
    logic useData;
  } dsn_note_s;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W/8-1:0] pstrb = 4'hF;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic fuseLoad = 1'b0;
  logic [IMG_W-1:0] fuseImage = 56'h0;
  dsn_note_s notes[$];
  int mismatches = 0;
  int samples_checked = 0;
  logic [IMG_W-1:0] img;

  always #5 clk = ~clk;

  dsn_serial_regs i_dsn_serial_regs (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuseLoad(fuseLoad), .fuseImage(fuseImage));

  // ==========================================================
  // reporting
  task automatic report(input string msg);
    mismatches++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  task automatic check_data(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    samples_checked++;
    if (got !== exp) report($sformatf("read data %h, expected %h", got, exp));
  endtask

  task automatic check_err(input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) report($sformatf("error flag %b, expected %b", got, exp));
  endtask

  task automatic complete_run();
    $display("mismatches %0d, samples checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // answer monitor: oldest note against each answer
  always @(posedge clk) begin : watch
    dsn_note_s nt;
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        report("answer without a request");
      end else begin
        nt = notes.pop_front();
        check_err(nt.err, pslverr);
        if (nt.useData) check_data(nt.data, prdata);
      end
    end
  end

  // ==========================================================
  // apb master; one idle cycle between transfers
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wdat,
                     input logic [DATA_W-1:0] expData, input logic expErr);
    int n;
    n = 0;
    notes.push_back('{data: expData, err: expErr, useData: !wr});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdat;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) report("no ready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [ADDR_W-1:0] addr_of(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction

  // expected word k of an image; word 0x0A bit 4 reads zero
  function automatic logic [DATA_W-1:0] word_of(input logic [IMG_W-1:0] im, input int k, input logic blank);
    logic [REG_W-1:0] b;
    b = im[IMG_W-1-8*k -: 8];
    if (k == 6) b = b & WORD6_MASK;
    if (blank) b = WORD_RESET;
    return DATA_W'(b);
  endfunction

  function automatic logic [IMG_W-1:0] make_image(input logic waferZero);
    logic [IMG_W-1:0] m;
    m = IMG_W'({$urandom(), $urandom()});
    for (int i = 0; i < CHAR_NUM; i++) m[CHAR_LSB[i] +: CHAR_W] = CHAR_W'($urandom_range(int'(CHAR_MAX)));
    m[WAFER_LSB +: WAFER_W] = waferZero ? 5'h00 : WAFER_W'($urandom_range(31, 1));
    return m;
  endfunction

  // load takes seven byte cycles after one idle cycle
  task automatic load(input logic [IMG_W-1:0] im);
    fuseImage <= im;
    fuseLoad <= 1'b1;
    @(posedge clk);
    fuseLoad <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  task automatic read_all(input logic [IMG_W-1:0] im, input logic blank);
    for (int k = 0; k < STORE_DEPTH; k++)
      apb(1'b0, addr_of(IDX_WORD0 + 6'(k)), 32'h0, word_of(im, k, blank), 1'b0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(57));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    read_all(56'h0, 1'b1);
    img = make_image(1'b0);
    load(img);
    read_all(img, 1'b0);
    apb(1'b0, addr_of(IDX_STATUS), 32'h0, 32'h7, 1'b0);
    for (int k = 0; k < STORE_DEPTH; k++) begin
      apb(1'b1, addr_of(IDX_WORD0 + 6'(k)), $urandom(), 32'h0, 1'b0);
      apb(1'b0, addr_of(IDX_WORD0 + 6'(k)), 32'h0, word_of(img, k, 1'b0), 1'b0);
    end
    apb(1'b0, 8'h0C, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h15, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h2C, 32'h0, 32'h0, 1'b1);
    // masking hides an image whose wafer number is zero
    apb(1'b1, addr_of(IDX_CTRL), 32'h1, 32'h0, 1'b0);
    apb(1'b0, addr_of(IDX_CTRL), 32'h0, 32'h1, 1'b0);
    // without the low strobe the control write is dropped
    pstrb <= 4'hE;
    apb(1'b1, addr_of(IDX_CTRL), 32'h0, 32'h0, 1'b0);
    pstrb <= 4'hF;
    apb(1'b0, addr_of(IDX_CTRL), 32'h0, 32'h1, 1'b0);
    img = make_image(1'b1);
    load(img);
    read_all(img, 1'b1);
    apb(1'b1, addr_of(IDX_STATUS), $urandom(), 32'h0, 1'b0);
    apb(1'b0, addr_of(IDX_STATUS), 32'h0, 32'h3, 1'b0);
    apb(1'b1, addr_of(IDX_CTRL), 32'h0, 32'h0, 1'b0);
    read_all(img, 1'b0);
    // reset in mid-run clears the loaded flag, so the stored image reads zero
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    read_all(img, 1'b1);
    repeat (2) @(posedge clk);
    if (notes.size() != 0) report("requests left unanswered");
    complete_run();
  end

  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    #50us;
    mismatches++;
    complete_run();
  end
endmodule // dsn_serial_regs_tb
